/* alias_mailbox_gpio_freq_defs.vh */
`ifndef ALIAS_MAILBOX_GPIO_FREQ_DEFS_VH
`define ALIAS_MAILBOX_GPIO_FREQ_DEFS_VH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_REMOTE_ALIAS_SIX     8'h16
`define IDX_REMOTE_ALIAS_SEVEN   8'h17
`define IDX_SCRATCH_MESSAGE_A    8'h18
`define IDX_SCRATCH_MESSAGE_B    8'h19
`define IDX_GLOBAL_PIN9_CONFIG   8'h1a
`define IDX_PIXEL_EDGE_METER     8'h1b

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_ALIAS                7'h00
`define RST_SCRATCH_A            8'h00
`define RST_SCRATCH_B            8'h01
`define RST_BYTE                 8'h00

// ----------------------------------------------------------------
// field positions in the pin configuration register
// ----------------------------------------------------------------
`define BIT_GLOBAL_LEVEL         7
`define BIT_GLOBAL_DIR           5
`define BIT_GLOBAL_EN            4
`define BIT_PIN9_LEVEL           3
`define BIT_PIN9_DIR             1
`define BIT_PIN9_EN              0
`define CFG_WRITABLE_MASK        8'hbb

// {direction, enable} encodings
`define MODE_FUNCTIONAL          2'b00
`define MODE_TRISTATE            2'b10
`define MODE_FORCE_OUT           2'b01
`define MODE_FORCE_IN            2'b11

// ----------------------------------------------------------------
// bus answers and timing
// ----------------------------------------------------------------
`define RESP_OKAY                2'b00
`define RESP_SLVERR              2'b10
`define OSC_PERIOD_NS            16'h0032
`define CLK_PERIOD_NS            16'h0064
`define EDGE_COUNT_MAX           8'hff
`define ZERO_PAD                 24'h00_0000

`endif

/* alias_mailbox_gpio_freq_regs.v */
// Notes on behaviour
// - two alias registers at 0x16 and 0x17 hold a 7-bit alias in bits 7-1, bit 0 reads zero, reset 0.
// - an i2c address equal to an alias is flagged remote and replaced by the paired target id.
// - an alias field of zero disables its entry so nothing is forwarded for it.
// - two 8-bit scratch registers at 0x18 and 0x19 only store messages, with no side effect.
// - scratch 0x18 resets to 0 and scratch 0x19 resets to 1.
// - the global level drives every pin not individually a gpio while the global mode is forced output.
// - global {dir,en}: 00 functional output, 10 tri-state, 01 forced output, 11 forced input.
// - a pin's own dir/en settings other than 00 win over the global ones; 00 defers to the global mode.
// - pin 9 shows its own level when gpio is on, direction is output and remote control is off.
// - pin 9 {dir,en}: 00 functional output, 10 tri-state, 01 gpio output, 11 gpio input.
// - writing N to 0x1b opens a window of N oscillator periods counting pixel clock edges.
// - reading 0x1b returns the edge count of the latest window, not the written value.
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`include "alias_mailbox_gpio_freq_defs.vh"

module alias_mailbox_gpio_freq_regs #(
  parameter ADDR_WIDTH = 8,
  parameter NUM_PINS   = 4
) (
  input  wire                  aclk,
  input  wire                  aresetn,
  input  wire [ADDR_WIDTH-1:0] s_axi_awaddr,
  input  wire                  s_axi_awvalid,
  output reg                   s_axi_awready,
  input  wire [31:0]           s_axi_wdata,
  input  wire [3:0]            s_axi_wstrb,
  input  wire                  s_axi_wvalid,
  output reg                   s_axi_wready,
  output reg  [1:0]            s_axi_bresp,
  output reg                   s_axi_bvalid,
  input  wire                  s_axi_bready,
  input  wire [ADDR_WIDTH-1:0] s_axi_araddr,
  input  wire                  s_axi_arvalid,
  output reg                   s_axi_arready,
  output reg  [31:0]           s_axi_rdata,
  output reg  [1:0]            s_axi_rresp,
  output reg                   s_axi_rvalid,
  input  wire                  s_axi_rready,
  input  wire [6:0]            i2c_addr,
  input  wire                  i2c_addr_valid,
  input  wire [6:0]            target_id_six,
  input  wire [6:0]            target_id_seven,
  output reg                   remote_hit,
  output reg  [6:0]            remote_addr,
  input  wire                  pixel_clk_pin,
  input  wire                  pin9_func_out,
  input  wire                  pin9_remote_en,
  input  wire                  pin9_remote_level,
  input  wire                  pin9_i,
  output reg                   pin9_o,
  output reg                   pin9_oe,
  output reg                   pin9_in_level,
  input  wire [NUM_PINS-1:0]   pin_gpio_active,
  input  wire [NUM_PINS-1:0]   pin_func_out,
  output reg  [NUM_PINS-1:0]   pin_global_o,
  output reg  [NUM_PINS-1:0]   pin_global_oe,
  output reg  [NUM_PINS-1:0]   pin_global_owned
);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  reg  [6:0]            alias_six_reg;
  reg  [6:0]            alias_seven_reg;
  reg  [7:0]            scratch_a_reg;
  reg  [7:0]            scratch_b_reg;
  reg  [7:0]            pin_cfg_reg;
  reg  [7:0]            edge_count_reg;
  reg  [15:0]           window_ns_reg;
  reg                   window_open_reg;
  reg                   aw_held_reg;
  reg                   w_held_reg;
  reg  [ADDR_WIDTH-1:0] aw_addr_reg;
  reg  [7:0]            w_data_reg;
  reg                   w_lane0_reg;
  reg  [2:0]            pix_sync_reg;
  reg  [1:0]            pin9_sync_reg;

  function is_mapped;
    input [ADDR_WIDTH-1:0] addr;
    begin
      is_mapped = (addr[1:0] == 2'b00) &&
                  (addr[ADDR_WIDTH-1:2] >= `IDX_REMOTE_ALIAS_SIX) &&
                  (addr[ADDR_WIDTH-1:2] <= `IDX_PIXEL_EDGE_METER);
    end
  endfunction

  function [7:0] read_value;
    input [ADDR_WIDTH-1:0] addr;
    begin
      case (addr[ADDR_WIDTH-1:2])
        `IDX_REMOTE_ALIAS_SIX:   read_value = {alias_six_reg, 1'b0};
        `IDX_REMOTE_ALIAS_SEVEN: read_value = {alias_seven_reg, 1'b0};
        `IDX_SCRATCH_MESSAGE_A:  read_value = scratch_a_reg;
        `IDX_SCRATCH_MESSAGE_B:  read_value = scratch_b_reg;
        `IDX_GLOBAL_PIN9_CONFIG: read_value = pin_cfg_reg;
        `IDX_PIXEL_EDGE_METER:   read_value = edge_count_reg;
        default:                 read_value = `RST_BYTE;
      endcase
    end
  endfunction

  // {oe, o} of a pad left to the global mode
  function [1:0] global_drive;
    input [1:0] mode;
    input       level;
    input       func_out;
    begin
      case (mode)
        `MODE_FORCE_OUT:                global_drive = {1'b1, level};
        `MODE_TRISTATE, `MODE_FORCE_IN: global_drive = 2'b00;
        default:                        global_drive = {1'b1, func_out};
      endcase
    end
  endfunction

  wire       wr_fire   = aw_held_reg && w_held_reg && !s_axi_bvalid;
  wire       wr_hit    = wr_fire && w_lane0_reg && is_mapped(aw_addr_reg);
  wire [5:0] wr_index  = aw_addr_reg[7:2];
  wire       meter_wr  = wr_hit && (wr_index == `IDX_PIXEL_EDGE_METER);
  wire       pix_rise  = pix_sync_reg[1] && !pix_sync_reg[2];
  wire [1:0] glob_mode = {pin_cfg_reg[`BIT_GLOBAL_DIR], pin_cfg_reg[`BIT_GLOBAL_EN]};
  wire [1:0] pin9_mode = {pin_cfg_reg[`BIT_PIN9_DIR], pin_cfg_reg[`BIT_PIN9_EN]};
  wire       glob_level = pin_cfg_reg[`BIT_GLOBAL_LEVEL];

  // ----------------------------------------------------------------
  // axi4-lite write and read channels
  // ----------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      aw_addr_reg   <= {ADDR_WIDTH{1'b0}};
      w_data_reg    <= `RST_BYTE;
      w_lane0_reg   <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `RESP_OKAY;
      s_axi_rdata   <= 32'h0000_0000;
    end
    else
    begin
      // ready is raised only while the holding slot is empty
      s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_held_reg && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg  <= 1'b1;
        w_data_reg  <= s_axi_wdata[7:0];
        w_lane0_reg <= s_axi_wstrb[0];
      end
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= is_mapped(aw_addr_reg) ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
      end
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= is_mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
        s_axi_rdata  <= {`ZERO_PAD, read_value(s_axi_araddr)};
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      alias_six_reg   <= `RST_ALIAS;
      alias_seven_reg <= `RST_ALIAS;
      scratch_a_reg   <= `RST_SCRATCH_A;
      scratch_b_reg   <= `RST_SCRATCH_B;
      pin_cfg_reg     <= `RST_BYTE;
    end
    else if (wr_hit)
    begin
      case (wr_index)
        `IDX_REMOTE_ALIAS_SIX:   alias_six_reg   <= w_data_reg[7:1];
        `IDX_REMOTE_ALIAS_SEVEN: alias_seven_reg <= w_data_reg[7:1];
        `IDX_SCRATCH_MESSAGE_A:  scratch_a_reg   <= w_data_reg;
        `IDX_SCRATCH_MESSAGE_B:  scratch_b_reg   <= w_data_reg;
        // bits 6 and 2 are reserved and stay zero
        `IDX_GLOBAL_PIN9_CONFIG: pin_cfg_reg <= w_data_reg & `CFG_WRITABLE_MASK;
        default:                 pin_cfg_reg <= pin_cfg_reg;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pixel clock edge meter
  // ----------------------------------------------------------------
  // the pixel clock is sampled by aclk, so it must stay below half the
  // aclk rate; faster clocks alias and read low
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pix_sync_reg    <= 3'b000;
      edge_count_reg  <= `RST_BYTE;
      window_ns_reg   <= 16'h0000;
      window_open_reg <= 1'b0;
    end
    else
    begin
      pix_sync_reg <= {pix_sync_reg[1:0], pixel_clk_pin};
      if (meter_wr)
      begin
        edge_count_reg  <= `RST_BYTE;
        window_ns_reg   <= w_data_reg * `OSC_PERIOD_NS;
        window_open_reg <= (w_data_reg != `RST_BYTE);
      end
      else if (window_open_reg)
      begin
        if (pix_rise && edge_count_reg != `EDGE_COUNT_MAX)
          edge_count_reg <= edge_count_reg + 8'h01;
        if (window_ns_reg <= `CLK_PERIOD_NS)
        begin
          window_ns_reg   <= 16'h0000;
          window_open_reg <= 1'b0;
        end
        else
          window_ns_reg <= window_ns_reg - `CLK_PERIOD_NS;
      end
    end
  end

  // ----------------------------------------------------------------
  // alias decode
  // ----------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      remote_hit  <= 1'b0;
      remote_addr <= 7'h00;
    end
    else if (i2c_addr_valid && alias_six_reg != `RST_ALIAS && i2c_addr == alias_six_reg)
    begin
      remote_hit  <= 1'b1;
      remote_addr <= target_id_six;
    end
    else if (i2c_addr_valid && alias_seven_reg != `RST_ALIAS && i2c_addr == alias_seven_reg)
    begin
      remote_hit  <= 1'b1;
      remote_addr <= target_id_seven;
    end
    else
    begin
      remote_hit  <= 1'b0;
      remote_addr <= 7'h00;
    end
  end

  // ----------------------------------------------------------------
  // pad control
  // ----------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin9_sync_reg <= 2'b00;
      pin9_in_level <= 1'b0;
      pin9_o        <= 1'b0;
      pin9_oe       <= 1'b0;
    end
    else
    begin
      pin9_sync_reg <= {pin9_sync_reg[0], pin9_i};
      pin9_in_level <= pin9_sync_reg[1];
      case (pin9_mode)
        `MODE_FORCE_OUT:
        begin
          pin9_o  <= pin9_remote_en ? pin9_remote_level
                                    : pin_cfg_reg[`BIT_PIN9_LEVEL];
          pin9_oe <= 1'b1;
        end
        `MODE_TRISTATE, `MODE_FORCE_IN:
          {pin9_oe, pin9_o} <= 2'b00;
        // own functional setting defers to the global mode
        default:
          {pin9_oe, pin9_o} <= global_drive(glob_mode, glob_level, pin9_func_out);
      endcase
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g = g + 1)
    begin : g_pin
      always @(posedge aclk)
      begin
        if (!aresetn)
        begin
          pin_global_o[g]     <= 1'b0;
          pin_global_oe[g]    <= 1'b0;
          pin_global_owned[g] <= 1'b0;
        end
        else
        begin
          pin_global_owned[g] <= !pin_gpio_active[g];
          {pin_global_oe[g], pin_global_o[g]} <= global_drive(glob_mode, glob_level,
                                                              pin_func_out[g]);
        end
      end
    end
  endgenerate

endmodule

/* alias_mailbox_gpio_freq_regs_assertions.sv */
`timescale 1ns/1ps
module alias_mailbox_gpio_freq_regs_assertions (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arready,
  input wire        s_axi_arvalid,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [6:0]  i2c_addr,
  input wire        i2c_addr_valid,
  input wire [6:0]  target_id_six,
  input wire [6:0]  target_id_seven,
  input wire        remote_hit,
  input wire [6:0]  remote_addr
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  write_gets_answer_a: assert property
    (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  bresp_stands_a: assert property
    (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  write_blocked_a: assert property
    (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken too early");
  read_gets_answer_a: assert property
    (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  rdata_stands_a: assert property
    (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  read_blocked_a: assert property
    (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
  upper_bits_zero_a: assert property
    (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000) else $error("upper read bits set");
  hit_has_cause_a: assert property
    (remote_hit |-> $past(i2c_addr_valid) && $past(i2c_addr) != 7'h00)
    else $error("remote hit without nonzero address");
  hit_addr_source_a: assert property
    (remote_hit |-> remote_addr == $past(target_id_six) || remote_addr == $past(target_id_seven))
    else $error("remote address not a target id");
  idle_addr_zero_a: assert property
    (!remote_hit |-> remote_addr == 7'h00) else $error("remote address without hit");
endmodule

bind alias_mailbox_gpio_freq_regs alias_mailbox_gpio_freq_regs_assertions
  alias_mailbox_gpio_freq_regs_assertions_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arready(s_axi_arready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .i2c_addr(i2c_addr), .i2c_addr_valid(i2c_addr_valid),
    .target_id_six(target_id_six), .target_id_seven(target_id_seven),
    .remote_hit(remote_hit), .remote_addr(remote_addr)
  );

/* alias_mailbox_gpio_freq_regs_tb_top.sv */
`timescale 1ns/1ps
`include "alias_mailbox_gpio_freq_defs.vh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module alias_mailbox_gpio_freq_regs_tb_top;
  reg         aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  reg         s_axi_arvalid = 0, s_axi_rready = 0, i2c_addr_valid = 0, pin9_func_out = 0;
  reg         pin9_remote_en = 0, pin9_remote_level = 0, pin9_i = 0;
  reg  [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, lfsr = 8'h4f, cfg;
  reg  [31:0] s_axi_wdata = 0, rd;
  reg  [3:0]  s_axi_wstrb = 0, pin_gpio_active = 0, pin_func_out = 0, g_oe, g_o, strb = 4'hf;
  reg  [6:0]  i2c_addr = 0, target_id_six = 7'h21, target_id_seven = 7'h52;
  reg  [2:0]  pdiv = 0;
  reg  [1:0]  rsp;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire        remote_hit, pin9_o, pin9_oe, pin9_in_level;
  wire        pixel_clk_pin = pdiv[2];
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [6:0]  remote_addr;
  wire [3:0]  pin_global_o, pin_global_oe, pin_global_owned;
  integer     n_errors = 0, samples_checked = 0, i, j, t;

  alias_mailbox_gpio_freq_regs alias_mailbox_gpio_freq_regs_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .i2c_addr(i2c_addr), .i2c_addr_valid(i2c_addr_valid),
    .target_id_six(target_id_six), .target_id_seven(target_id_seven),
    .remote_hit(remote_hit), .remote_addr(remote_addr),
    .pixel_clk_pin(pixel_clk_pin), .pin9_func_out(pin9_func_out),
    .pin9_remote_en(pin9_remote_en), .pin9_remote_level(pin9_remote_level),
    .pin9_i(pin9_i), .pin9_o(pin9_o), .pin9_oe(pin9_oe), .pin9_in_level(pin9_in_level),
    .pin_gpio_active(pin_gpio_active), .pin_func_out(pin_func_out),
    .pin_global_o(pin_global_o), .pin_global_oe(pin_global_oe),
    .pin_global_owned(pin_global_owned)
  );

  always #50 aclk = ~aclk;
  // free running pixel clock of eight aclk periods, well under the 5 MHz limit
  always @(posedge aclk) pdiv <= pdiv + 3'd1;

  function [7:0] nxt(input [7:0] s);
    nxt = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // {oe, o} of pin 9, o forced low while not driven
  function [1:0] pin9_exp(input [7:0] c);
    begin
      if (c[1:0] == `MODE_FORCE_OUT)
        pin9_exp = {1'b1, pin9_remote_en ? pin9_remote_level : c[3]};
      else if (c[1:0] != `MODE_FUNCTIONAL || c[5])
        pin9_exp = 2'b00;
      else
        pin9_exp = {1'b1, c[4] ? c[7] : pin9_func_out};
    end
  endfunction

  task axi_wr(input [7:0] idx, input [7:0] d, input [1:0] er);
    reg aw, w, b;
    begin
      @(posedge aclk);
      b = 0;
      t = 0;
      s_axi_awaddr <= {idx[5:0], 2'b00};
      s_axi_wdata <= {24'h00_0000, d};
      s_axi_wstrb <= strb;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!b && t < 100)
      begin
        @(negedge aclk);
        t = t + 1;
        aw = s_axi_awready;
        w = s_axi_wready;
        b = s_axi_bvalid;
        rsp = s_axi_bresp;
        @(posedge aclk);
        if (aw) s_axi_awvalid <= 1'b0;
        if (w) s_axi_wvalid <= 1'b0;
        if (b) s_axi_bready <= 1'b0;
      end
      `CHK("bvalid", 1'b1, b)
      `CHK("bresp", er, rsp)
    end
  endtask

  task axi_rd(input [7:0] idx, input [1:0] er);
    reg a, r;
    begin
      @(posedge aclk);
      r = 0;
      t = 0;
      s_axi_araddr <= {idx[5:0], 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!r && t < 100)
      begin
        @(negedge aclk);
        t = t + 1;
        a = s_axi_arready;
        r = s_axi_rvalid;
        rsp = s_axi_rresp;
        rd = s_axi_rdata;
        @(posedge aclk);
        if (a) s_axi_arvalid <= 1'b0;
        if (r) s_axi_rready <= 1'b0;
      end
      `CHK("rvalid", 1'b1, r)
      `CHK("rresp", er, rsp)
    end
  endtask

  task decode(input [6:0] a, input h, input [6:0] ea);
    begin
      @(posedge aclk);
      i2c_addr <= a;
      i2c_addr_valid <= 1'b1;
      @(posedge aclk);
      i2c_addr_valid <= 1'b0;
      @(negedge aclk);
      `CHK("remote_hit", h, remote_hit)
      `CHK("remote_addr", ea, remote_addr)
    end
  endtask

  // window is ceil(n/2) aclk cycles; one pixel edge per eight cycles, one edge of slack
  task meter(input [7:0] n);
    integer e;
    begin
      e = ((n + 1) / 2) / 8;
      axi_wr(`IDX_PIXEL_EDGE_METER, n, `RESP_OKAY);
      repeat (n / 2 + 6) @(posedge aclk);
      axi_rd(`IDX_PIXEL_EDGE_METER, `RESP_OKAY);
      `CHK("edge count", 1'b1, (rd + 1 >= e) && (rd <= e + 1))
    end
  endtask

  task final_report;
    begin
      $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 6; i = i + 1)
    begin
      axi_rd(`IDX_REMOTE_ALIAS_SIX + i[7:0], `RESP_OKAY);
      `CHK("reset value", (i == 3) ? 32'h0000_0001 : 32'h0000_0000, rd)
    end
    for (j = 0; j < 20; j = j + 1)
    begin
      lfsr = nxt(lfsr);
      i = j % 5;
      axi_wr(`IDX_REMOTE_ALIAS_SIX + i[7:0], lfsr, `RESP_OKAY);
      axi_rd(`IDX_REMOTE_ALIAS_SIX + i[7:0], `RESP_OKAY);
      cfg = (i < 2) ? 8'hfe : (i == 4) ? 8'hbb : 8'hff;
      `CHK("readback", {24'h00_0000, lfsr & cfg}, rd)
    end
    axi_wr(8'h1c, 8'h55, `RESP_SLVERR);
    axi_rd(8'h1c, `RESP_SLVERR);
    `CHK("unmapped data", 32'h0000_0000, rd)
    // a write without byte lane 0 must leave the register alone
    axi_wr(`IDX_SCRATCH_MESSAGE_A, 8'hc3, `RESP_OKAY);
    strb = 4'he;
    axi_wr(`IDX_SCRATCH_MESSAGE_A, 8'h3c, `RESP_OKAY);
    strb = 4'hf;
    axi_rd(`IDX_SCRATCH_MESSAGE_A, `RESP_OKAY);
    `CHK("masked write", 32'h0000_00c3, rd)
    lfsr = nxt(lfsr);
    target_id_six <= lfsr[6:0];
    target_id_seven <= ~lfsr[6:0];
    axi_wr(`IDX_REMOTE_ALIAS_SIX, 8'h66, `RESP_OKAY);
    axi_wr(`IDX_REMOTE_ALIAS_SEVEN, 8'h9a, `RESP_OKAY);
    decode(7'h33, 1'b1, target_id_six);
    decode(7'h4d, 1'b1, target_id_seven);
    decode(7'h34, 1'b0, 7'h00);
    axi_wr(`IDX_REMOTE_ALIAS_SIX, 8'h00, `RESP_OKAY);
    decode(7'h33, 1'b0, 7'h00);
    decode(7'h00, 1'b0, 7'h00);
    for (j = 0; j < 16; j = j + 1)
    begin
      lfsr = nxt(lfsr);
      cfg = {lfsr[7], 1'b0, j[3:2], lfsr[3], 1'b0, j[1:0]};
      @(posedge aclk);
      pin9_func_out <= lfsr[0];
      pin9_remote_en <= lfsr[1];
      pin9_remote_level <= lfsr[2];
      pin9_i <= lfsr[5];
      pin_gpio_active <= lfsr[7:4];
      pin_func_out <= lfsr[3:0];
      axi_wr(`IDX_GLOBAL_PIN9_CONFIG, cfg, `RESP_OKAY);
      repeat (3) @(posedge aclk);
      @(negedge aclk);
      g_oe = {4{!cfg[5]}};
      g_o = (cfg[4] ? {4{cfg[7]}} : pin_func_out) & g_oe;
      `CHK("pin9 drive", pin9_exp(cfg), {pin9_oe, pin9_oe & pin9_o})
      `CHK("owned", ~pin_gpio_active, pin_global_owned)
      `CHK("global pads", {g_oe, g_o}, {pin_global_oe, pin_global_o})
      `CHK("pad input", pin9_i, pin9_in_level)
    end
    meter(8'd160);
    meter(8'd0);
    `CHK("empty window", 32'h0000_0000, rd)
    axi_wr(`IDX_PIXEL_EDGE_METER, 8'd200, `RESP_OKAY);
    repeat (60) @(posedge aclk);
    meter(8'd8);
    i = rd;
    repeat (60) @(posedge aclk);
    axi_rd(`IDX_PIXEL_EDGE_METER, `RESP_OKAY);
    `CHK("restarted window", i, rd)
    for (j = 0; j < 3; j = j + 1)
    begin
      lfsr = nxt(lfsr);
      meter(lfsr);
    end
    final_report;
  end

  initial
  begin
    #(100 * 20000);
    n_errors = n_errors + 1;
    final_report;
  end
endmodule
